/* common/mps_pkg.sv */
// Constants, register map and carrier types of the multi-position sequencer.
// Assumes one 20 MHz drive clock and a 32-bit APB register bus.
package mps_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [11:0] REG_CTRL     = 12'h000;
	localparam logic [11:0] REG_STATUS   = 12'h004;
	localparam logic [11:0] REG_EV_STAT  = 12'h008;
	localparam logic [11:0] REG_EV_MASK  = 12'h00c;
	localparam logic [3:0]  PROF_REGION  = 4'h1;
	localparam logic [1:0]  PROF_W_DISP  = 2'h0;
	localparam logic [1:0]  PROF_W_SPEED = 2'h1;
	localparam logic [1:0]  PROF_W_ACC   = 2'h2;

	// ------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------
	localparam int unsigned CTRL_MODE_LSB  = 0;
	localparam int unsigned CTRL_END_LSB   = 4;
	localparam int unsigned CTRL_RSTRT_LSB = 8;
	localparam int unsigned CTRL_RULE_BIT  = 16;
	localparam int unsigned CTRL_STOP_BIT  = 17;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_00f0;
	localparam logic [15:0] SPEED_RESET    = 16'h00c8;
	localparam logic [15:0] ACC_RESET      = 16'h000a;
	localparam logic [31:0] DISP_RESET     = 32'h0000_2710;

	// ------------------------------------------------------------
	// Events and modes
	// ------------------------------------------------------------
	localparam int unsigned EV_POS = 0;
	localparam int unsigned EV_CYC = 1;
	localparam int unsigned EV_SON = 2;
	localparam int unsigned EV_EN  = 3;
	localparam int unsigned EV_W   = 4;

	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_CYCLIC = 2'h1;
	localparam logic [1:0] MODE_DI     = 2'h2;
	localparam logic [1:0] MODE_SEQ    = 2'h3;

	localparam int unsigned NUM_POS = 16;

	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOP} mps_state_type;

	typedef struct packed {
		logic [31:0] disp;
		logic [15:0] speed;
		logic [15:0] acc;
	} mps_prof_type;

	typedef struct packed {
		mps_prof_type prof;
		logic         dir;
	} mps_move_type;

	typedef struct packed {
		logic [3:0] sel;
		logic       en;
		logic       son;
		logic       dir;
	} mps_pins_type;

endpackage : mps_pkg

/* rtl/mps_sequencer.sv */
// Multi-position reference sequencer: picks stored displacement profiles and
// hands them to the motion generator. Assumes the generator shares mclk_i and
// that the terminal inputs are asynchronous to it.
//
// Operation
// [R01] Four select inputs form position number, LSB first.
// [R02] Select inputs are level sensitive.
// [R03] Mode code 3 selects sequential running.
// [R04] Cycles restart at restart setting, else stop.
// [R05] Advance automatically to next higher position.
// [R06] No wait between consecutive positions.
// [R07] Controller assigns a terminal the enable function.
// [R08] Positioning done asserts after each position; the code asserts it only when no next position starts (mode 2, or end of a pass that does not restart).
// [R09] Controller maps positioning done to an output.
// [R10] Servo-off stops; done stays inactive afterwards.
// [R11] Enable loss discards, stops, then asserts done.
// [R12] Re-enable picks start by start-position setting.
// [R13] Direction latched at position start.
// [R14] Sixteen profiles: displacement, speed, acceleration.
// [R15] Enable level sensitive, edge sensitive mode 2.
// [R16] Reset leaves sequencer idle, done inactive.
`timescale 1ns/1ns
module mps_sequencer
	import mps_pkg::*;
(
	input  wire logic         mclk_i,
	input  wire logic         resetn_i,
	input  wire logic         psel_i,
	input  wire logic         penable_i,
	input  wire logic         pwrite_i,
	input  wire logic [11:0]  paddr_i,
	input  wire logic [31:0]  pwdata_i,
	output logic      [31:0]  prdata_o,
	output logic              pready_o,
	output logic              pslverr_o,
	input  wire logic [3:0]   pos_select_i,
	input  wire logic         multi_pos_enable_i,
	input  wire logic         servo_on_i,
	input  wire logic         ref_direction_select_i,
	input  wire logic         move_done_i,
	input  wire logic         motor_stopped_i,
	output logic              move_start_o,
	output logic              move_abort_o,
	output mps_move_type      move_cmd_o,
	output logic              stop_mode_o,
	output logic              positioning_done_o,
	output logic              irq_o
);

	// ------------------------------------------------------------
	// Terminal synchronisers
	// ------------------------------------------------------------
	mps_pins_type sync1_ff;
	mps_pins_type pins_ff;
	logic         en_prev_ff;

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sync1_ff   <= '0;
			pins_ff    <= '0;
			en_prev_ff <= 1'b0;
		end
		else
		begin
			sync1_ff   <= {pos_select_i, multi_pos_enable_i, servo_on_i, ref_direction_select_i};
			pins_ff    <= sync1_ff;
			en_prev_ff <= pins_ff.en;
		end
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [31:0]       ctrl_ff;
	logic [EV_W-1:0]   ev_stat_ff;
	logic [EV_W-1:0]   ev_mask_ff;
	logic [EV_W-1:0]   ev_set;
	mps_prof_type      prof_ff [NUM_POS];
	logic              pready_ff;
	logic              pslverr_ff;
	logic [31:0]       prdata_ff;
	logic              irq_ff;
	logic              acc_phase;
	logic              wr_done;
	logic              is_prof;
	logic [3:0]        prof_sel;
	logic [31:0]       rd_val;
	logic              rd_ok;

	mps_state_type     state_ff;
	logic [3:0]        idx_ff;
	logic              done_ff;

	assign acc_phase = psel_i & penable_i;
	assign wr_done   = acc_phase & pready_ff & pwrite_i & ~pslverr_ff;
	assign is_prof   = (paddr_i[11:8] == PROF_REGION) & (paddr_i[3:2] != 2'h3) & (paddr_i[1:0] == 2'h0);
	assign prof_sel  = paddr_i[7:4];

	always_comb
	begin
		rd_val = 32'h0000_0000;
		rd_ok  = 1'b1;
		if (is_prof)
		begin
			case (paddr_i[3:2])
				PROF_W_DISP:  rd_val = prof_ff[prof_sel].disp;
				PROF_W_SPEED: rd_val = {16'h0000, prof_ff[prof_sel].speed};
				default:      rd_val = {16'h0000, prof_ff[prof_sel].acc};
			endcase
		end
		else
		begin
			case (paddr_i)
				REG_CTRL:    rd_val = ctrl_ff;
				REG_STATUS:  rd_val = {24'h00_0000, idx_ff, 1'b0, done_ff, state_ff};
				REG_EV_STAT: rd_val = {28'h000_0000, ev_stat_ff};
				REG_EV_MASK: rd_val = {28'h000_0000, ev_mask_ff};
				default:     rd_ok  = 1'b0;
			endcase
		end
	end

	// One wait state: the slave answers in the second access cycle.
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end
		else if (acc_phase & ~pready_ff)
		begin
			pready_ff  <= 1'b1;
			pslverr_ff <= ~rd_ok;
			prdata_ff  <= pwrite_i ? 32'h0000_0000 : rd_val;
		end
		else
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ctrl_ff    <= CTRL_RESET;
			ev_mask_ff <= '0;
		end
		else if (wr_done)
		begin
			if (paddr_i == REG_CTRL)
				ctrl_ff <= pwdata_i;
			if (paddr_i == REG_EV_MASK)
				ev_mask_ff <= pwdata_i[EV_W-1:0];
		end
	end

	// Write-one-to-clear; a new event in the same cycle wins over the clear.
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			ev_stat_ff <= '0;
		else if (wr_done && paddr_i == REG_EV_STAT)
			ev_stat_ff <= (ev_stat_ff & ~pwdata_i[EV_W-1:0]) | ev_set;
		else
			ev_stat_ff <= ev_stat_ff | ev_set;
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(ev_stat_ff & ev_mask_ff);
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_POS; gi++)
		begin : g_prof
			always_ff @(posedge mclk_i or negedge resetn_i)
			begin
				if (!resetn_i)
					prof_ff[gi] <= '{disp: DISP_RESET, speed: SPEED_RESET, acc: ACC_RESET}; // [R14]
				else if (wr_done && is_prof && prof_sel == 4'(gi))
				begin
					case (paddr_i[3:2])
						PROF_W_DISP:  prof_ff[gi].disp  <= pwdata_i;
						PROF_W_SPEED: prof_ff[gi].speed <= pwdata_i[15:0];
						default:      prof_ff[gi].acc   <= pwdata_i[15:0];
					endcase
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	logic [1:0]    mode;
	logic [3:0]    end_idx;
	logic [4:0]    rstrt_pos;
	logic          single;
	logic          en_rise;
	logic          finished_ff;
	logic          son_abort_ff;
	mps_state_type nxt_state;
	logic [3:0]    nxt_idx;
	logic          nxt_finished;
	logic          nxt_son_abort;
	logic          nxt_start;
	logic          nxt_abort;

	assign mode      = ctrl_ff[CTRL_MODE_LSB +: 2];
	assign end_idx   = ctrl_ff[CTRL_END_LSB +: 4];
	assign rstrt_pos = ctrl_ff[CTRL_RSTRT_LSB +: 5];
	assign single    = (rstrt_pos == 5'h00) || (rstrt_pos > ({1'b0, end_idx} + 5'h01)); // [R04]
	assign en_rise   = pins_ff.en & ~en_prev_ff; // [R15]

	always_comb
	begin
		nxt_state     = state_ff;
		nxt_idx       = idx_ff;
		nxt_finished  = finished_ff;
		nxt_son_abort = son_abort_ff;
		nxt_start     = 1'b0;
		nxt_abort     = 1'b0;
		ev_set        = '0;
		// A finished pass is re-armed by dropping the enable level.
		if (mode != MODE_DI && !pins_ff.en)
			nxt_finished = 1'b0;
		case (state_ff)
			ST_IDLE:
			begin
				if (pins_ff.son)
				begin
					if (mode == MODE_DI)
					begin
						if (en_rise) // [R15]
						begin
							nxt_idx   = pins_ff.sel; // [R01] [R02]
							nxt_start = 1'b1;
							nxt_state = ST_RUN;
						end
					end
					else if (pins_ff.en && !finished_ff) // [R15]
					begin
						nxt_start = 1'b1;
						nxt_state = ST_RUN;
					end
				end
			end
			ST_RUN:
			begin
				if (!pins_ff.son)
				begin
					nxt_abort          = 1'b1; // [R10]
					nxt_son_abort      = 1'b1;
					ev_set[EV_SON]     = 1'b1;
					nxt_state          = ST_STOP;
				end
				else if (mode != MODE_DI && !pins_ff.en)
				begin
					nxt_abort          = 1'b1; // [R11]
					nxt_son_abort      = 1'b0;
					ev_set[EV_EN]      = 1'b1;
					nxt_state          = ST_STOP;
					if (ctrl_ff[CTRL_RULE_BIT])
						nxt_idx = 4'h0; // [R12]
				end
				else if (move_done_i)
				begin
					ev_set[EV_POS] = 1'b1;
					if (mode == MODE_DI)
						nxt_state = ST_IDLE;
					else if (idx_ff == end_idx)
					begin
						ev_set[EV_CYC] = 1'b1;
						if (mode == MODE_SINGLE || (mode == MODE_SEQ && single)) // [R03] [R04]
						begin
							nxt_finished = 1'b1;
							nxt_idx      = 4'h0;
							nxt_state    = ST_IDLE;
						end
						else
						begin
							nxt_idx   = (mode == MODE_SEQ) ? rstrt_pos[3:0] - 4'h1 : 4'h0; // [R04]
							nxt_start = 1'b1; // [R06]
						end
					end
					else
					begin
						nxt_idx   = idx_ff + 4'h1; // [R05]
						nxt_start = 1'b1; // [R06]
					end
				end
			end
			ST_STOP:
			begin
				if (motor_stopped_i)
					nxt_state = ST_IDLE;
			end
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_ff     <= ST_IDLE; // [R16]
			idx_ff       <= 4'h0;
			finished_ff  <= 1'b0;
			son_abort_ff <= 1'b0;
		end
		else
		begin
			state_ff     <= nxt_state;
			idx_ff       <= nxt_idx;
			finished_ff  <= nxt_finished;
			son_abort_ff <= nxt_son_abort;
		end
	end

	// ------------------------------------------------------------
	// Motion generator command and completion output
	// ------------------------------------------------------------
	logic         start_ff;
	logic         abort_ff;
	mps_move_type cmd_ff;
	logic         stop_mode_ff;

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			start_ff     <= 1'b0;
			abort_ff     <= 1'b0;
			cmd_ff       <= '0;
			stop_mode_ff <= 1'b0;
		end
		else
		begin
			start_ff     <= nxt_start;
			abort_ff     <= nxt_abort;
			stop_mode_ff <= ctrl_ff[CTRL_STOP_BIT]; // [R10]
			if (nxt_start)
				cmd_ff <= '{prof: prof_ff[nxt_idx], dir: pins_ff.dir}; // [R13]
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			done_ff <= 1'b0; // [R16]
		else if (nxt_start)
			done_ff <= 1'b0;
		else if (ev_set[EV_POS])
			done_ff <= 1'b1; // [R08]
		else if (ev_set[EV_SON])
			done_ff <= 1'b0; // [R10]
		else if (state_ff == ST_STOP && motor_stopped_i)
			done_ff <= ~son_abort_ff; // [R10] [R11]
	end

	assign prdata_o           = prdata_ff;
	assign pready_o           = pready_ff;
	assign pslverr_o          = pslverr_ff;
	assign move_start_o       = start_ff;
	assign move_abort_o       = abort_ff;
	assign move_cmd_o         = cmd_ff;
	assign stop_mode_o        = stop_mode_ff;
	assign positioning_done_o = done_ff;
	assign irq_o              = irq_ff;

endmodule : mps_sequencer

/* bench/mps_motion_model.sv */
// Behavioural motion generator facing the sequencer's move interface.
// Assumes the sequencer's clock and reset; alternates short and long moves.
`timescale 1ns/1ns
module mps_motion_model
(
	input  wire logic clk_i,
	input  wire logic resetn_i,
	input  wire logic start_i,
	input  wire logic abort_i,
	output logic      done_o,
	output logic      stopped_o
);
	logic [3:0] cnt_ff;
	logic       busy_ff;
	logic       slow_ff;

	// Each start loads a fresh count; an abort drops the move and the motor comes to rest later.
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cnt_ff    <= 4'h0;
			busy_ff   <= 1'b0;
			slow_ff   <= 1'b0;
			done_o    <= 1'b0;
			stopped_o <= 1'b1;
		end
		else
		begin
			done_o <= 1'b0;
			if (start_i)
			begin
				busy_ff   <= 1'b1;
				stopped_o <= 1'b0;
				cnt_ff    <= slow_ff ? 4'hb : 4'h2;
				slow_ff   <= !slow_ff;
			end
			else if (abort_i)
			begin
				busy_ff <= 1'b0;
				cnt_ff  <= 4'h3;
			end
			else if (cnt_ff != 4'h0)
				cnt_ff <= cnt_ff - 4'h1;
			else
			begin
				done_o    <= busy_ff;
				busy_ff   <= 1'b0;
				stopped_o <= !busy_ff;
			end
		end
	end
endmodule : mps_motion_model

/* bench/mps_sequencer_props.sv */
// Port-level properties of the multi-position sequencer.
// Assumes binding to mps_sequencer; one clock domain.
`timescale 1ns/1ns
module mps_sequencer_props
	import mps_pkg::*;
(
	input wire logic         mclk_i,
	input wire logic         resetn_i,
	input wire logic         psel_i,
	input wire logic         penable_i,
	input wire logic         pready_o,
	input wire logic         servo_on_i,
	input wire logic         move_done_i,
	input wire logic         move_start_o,
	input wire logic         move_abort_o,
	input wire mps_move_type move_cmd_o,
	input wire logic         positioning_done_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	logic run_ff;

	// Tracks whether a move is in flight.
	always_ff @(posedge mclk_i or negedge resetn_i)
		if (!resetn_i)
			run_ff <= 1'b0;
		else if (move_start_o)
			run_ff <= 1'b1;
		else if (move_done_i || move_abort_o)
			run_ff <= 1'b0;

	AST_APB_WAIT: assert property (psel_i && $rose(penable_i) |=> pready_o)
		else $error("ready not in second access cycle");
	AST_RESET_IDLE: assert property ($rose(resetn_i) |-> !positioning_done_o && !move_start_o)
		else $error("not idle after reset");
	AST_START_PULSE: assert property (move_start_o |=> !move_start_o)
		else $error("start longer than one cycle");
	// A finish that meets an abort in the same cycle is dropped by the stop sequence.
	AST_DONE_NEXT: assert property (move_done_i && !move_abort_o |=> positioning_done_o || move_start_o)
		else $error("no done and no next start");
	AST_CMD_HOLD: assert property (!move_start_o |-> $stable(move_cmd_o))
		else $error("command changed mid move");
	AST_SON_ABORT: assert property ($fell(servo_on_i) && run_ff |-> ##[1:5] (move_abort_o || !run_ff))
		else $error("no abort on servo off");
	AST_SON_DONE: assert property (move_abort_o && !servo_on_i |=> !positioning_done_o [*8])
		else $error("done after servo abort");
	AST_EN_DONE: assert property (move_abort_o && servo_on_i |-> ##[1:40] positioning_done_o)
		else $error("no done after enable abort");
	AST_ABORT_RUN: assert property (move_abort_o |-> run_ff)
		else $error("abort while idle");
	AST_NO_START_OFF: assert property (!servo_on_i [*5] |-> !move_start_o)
		else $error("start with servo off");

	cover property (move_done_i ##1 move_start_o);
	cover property (move_abort_o && servo_on_i);
	cover property (move_abort_o && !servo_on_i);
endmodule : mps_sequencer_props

/* bench/mps_sequencer_tb.sv */
// Self-checking bench for the multi-position sequencer.
// Assumes mps_pkg and the motion model; APB master tasks drive registers.
`timescale 1ns/1ns
module mps_sequencer_tb;
	import mps_pkg::*;
	logic         clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, en = 0, son = 0, dir = 0;
	logic [11:0]  addr = 0;
	logic [31:0]  wdat = 0, q, rdat;
	logic [3:0]   sel = 0;
	logic         perr, rdy, err, start, abort, stopm, done, irq, mdone, mstop;
	mps_move_type cmd;
	logic [3:0]   tv [8] = '{1, 2, 4, 8, 5, 15, 10, 0};
	int           fail_count = 0, checks_done = 0, nst = 0, n0, i;

	mps_sequencer mps_sequencer_i (.mclk_i(clk), .resetn_i(rst_n), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdat), .prdata_o(rdat), .pready_o(rdy),
		.pslverr_o(err), .pos_select_i(sel), .multi_pos_enable_i(en), .servo_on_i(son),
		.ref_direction_select_i(dir), .move_done_i(mdone), .motor_stopped_i(mstop),
		.move_start_o(start), .move_abort_o(abort), .move_cmd_o(cmd), .stop_mode_o(stopm),
		.positioning_done_o(done), .irq_o(irq));
	mps_motion_model mps_motion_model_i (.clk_i(clk), .resetn_i(rst_n), .start_i(start),
		.abort_i(abort), .done_o(mdone), .stopped_o(mstop));

	initial forever #25 clk = ~clk;
	always @(posedge clk) if (start === 1'b1) nst <= nst + 1;

	task chk(input string n, input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task finish_test;
		if (fail_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1; pwr <= w; addr <= a; wdat <= d;
		@(posedge clk);
		pen <= 1;
		for (n = 0; n < 20 && rdy !== 1'b1; n++) @(posedge clk);
		if (n == 20)
		begin
			fail_count++;
			finish_test;
		end
		q = rdat; perr = err; psel <= 0; pen <= 0;
	endtask : apb

	task wt(input int k);
		logic [3:0] v;
		for (int n = 0; n < 40; n++)
		begin
			@(posedge clk);
			v = {abort, done, mdone, start};
			if (v[k] === 1'b1) return;
		end
		fail_count++;
		finish_test;
	endtask : wt

	task seq(input int n, input int x, input int r, input int e, input logic more);
		wt(0);
		for (int k = 0; k < n; k++)
		begin
			chk("seq", cmd.prof.disp, 32'h100 + x);
			wt(1);
			@(posedge clk);
			chk("gap", start, k < n - 1 || more);
			x = (x == e) ? r : x + 1;
		end
	endtask : seq

	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1;
		chk("done", done, 0);
		apb(0, REG_CTRL, 0);
		chk("ctrl", q, CTRL_RESET);
		apb(0, 12'h010, 0);
		chk("err", perr, 1);
		apb(0, 12'h134, 0);
		chk("speed", q, 32'(SPEED_RESET));
		for (i = 0; i < 16; i++) apb(1, 12'h100 + 12'(i * 16), 32'h100 + i);
		apb(1, REG_EV_MASK, 1);
		// Select-input mode with the stop-mode bit set.
		apb(1, REG_CTRL, {14'h0, 1'b1, 15'h0, MODE_DI});
		son <= 1;
		// The last selection is position 0, so the sequential pass starts there.
		for (i = 0; i < 8; i++)
		begin
			sel <= tv[i];
			dir <= i[0];
			repeat (4) @(posedge clk);
			en <= 1;
			wt(0);
			chk("pos", cmd.prof.disp, 32'h100 + tv[i]);
			dir <= !i[0];
			wt(2);
			chk("dir", cmd.dir, i[0]);
			@(posedge clk);
			chk("irq", irq, 1);
			en <= 0;
			apb(1, REG_EV_STAT, 32'h1f);
			repeat (2) @(posedge clk);
			chk("irq", irq, 0);
		end
		chk("stopm", stopm, 1);
		apb(1, REG_CTRL, 32'h33);
		en <= 1;
		seq(4, 0, 0, 3, 0);
		chk("done", done, 1);
		chk("stopm", stopm, 0);
		n0 = nst;
		repeat (30) @(posedge clk);
		chk("again", nst, n0);
		en <= 0;
		apb(1, REG_CTRL, 32'h1_0223);
		en <= 1;
		seq(5, 0, 1, 2, 1);
		en <= 0;
		wt(3);
		wt(2);
		chk("stopdone", done, 1);
		apb(0, REG_STATUS, 0);
		chk("status", q, {28'h000_0000, 2'b01, ST_IDLE});
		apb(0, REG_EV_STAT, 0);
		chk("ev_en", q[3], 1);
		en <= 1;
		wt(0);
		chk("resume", cmd.prof.disp, 32'h100);
		son <= 0;
		wt(3);
		repeat (10) @(posedge clk);
		chk("soff", done, 0);
		apb(1, REG_EV_STAT, 1);
		repeat (2) @(posedge clk);
		chk("mask", irq, 0);
		apb(0, REG_EV_STAT, 0);
		chk("ev_son", q[2], 1);
		finish_test;
	end
endmodule : mps_sequencer_tb

bind mps_sequencer mps_sequencer_props mps_sequencer_props_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
	.psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .servo_on_i(servo_on_i),
	.move_done_i(move_done_i), .move_start_o(move_start_o), .move_abort_o(move_abort_o),
	.move_cmd_o(move_cmd_o), .positioning_done_o(positioning_done_o));
